// File: rtl/dtc_cfg.svh
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_MHZ 125
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC (`BLINK_HALF_MS * 1000 * `CLK_MHZ)

// ----------------------------------------------------------------
// configuration word on data-in: 11 mm llll
// ----------------------------------------------------------------
`define CFG_TAG 2'b11
`define CMD_TAG 2'b10
`define CFG_MODE_HI 5
`define CFG_MODE_LO 4
`define CFG_LEN_HI 3
`define CFG_LEN_LO 0
`define LEN_CODE_MAX 4'hb
`define LEN_CODE_32 4'h7
`define DEF_LEN_CODE 4'h7
`define MAX_CHARS 48
`define RB_WORDS 6'h22
`define SPACE_CODE 7'h20
`define CURSOR_COL 7'h7f

// ----------------------------------------------------------------
// command codes, low three bits of 10xx xccc
// ----------------------------------------------------------------
`define CMD_CLEAR 3'h0
`define CMD_BACK 3'h1
`define CMD_FWD 3'h2
`define CMD_INSERT 3'h3
`define CMD_DELETE 3'h4
`define CMD_READ 3'h5
`define CMD_SETPOS 3'h6

// ----------------------------------------------------------------
// apb map
// ----------------------------------------------------------------
`define REG_CONFIG 8'h00
`define REG_FONT 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0c
`define REG_CURSOR 8'h10
`define EV_RBDONE 0
`define EV_ENDKEY 1
`define EV_REFUSED 2
`define EV_WIDTH 3

`endif

// File: rtl/dtc_pkg.sv
package dtc_pkg;
  typedef enum logic [1:0] {
    ENTRY_LEFT,
    ENTRY_RIGHT,
    ENTRY_DIRECT,
    ENTRY_BLOCK
  } entry_mode_t;

  typedef enum logic [1:0] {
    FONT_64,
    FONT_128,
    FONT_EXT
  } font_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_READ
  } ctl_state_t;
endpackage

// File: rtl/blink_timer.sv
`timescale 1ns/100ps
module blink_timer #(
  parameter int unsigned HALF_CYCLES = 31250000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // blink phase
  output logic phase
);
  logic [31:0] count_r;
  logic phase_r;
  wire wrap = (count_r == 32'(HALF_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 32'h0;
      phase_r <= 1'b0;
    end else begin
      count_r <= wrap ? 32'h0 : count_r + 32'h1;
      if (wrap) begin
        phase_r <= ~phase_r;
      end
    end
  end

  assign phase = phase_r;
endmodule // blink_timer

// File: rtl/font_addr.sv
`timescale 1ns/100ps
module font_addr
  import dtc_pkg::*;
(
  // character and column
  input wire logic [6:0] charCode,
  input wire logic [2:0] col,
  input font_sel_t fontSel,
  // code memory address
  output logic [9:0] addr
);
  // the 64 set folds lower case onto upper and controls onto blank
  wire [6:0] upper = (charCode >= 7'h60) ? charCode - 7'h20 : charCode;
  wire [6:0] folded = (upper < 7'h20) ? 7'h20 : upper;
  wire [5:0] idx64 = 6'(folded - 7'h20);

  assign addr = (fontSel == FONT_64) ? {col, 1'b0, idx64} : {col, charCode};
endmodule // font_addr

// File: rtl/display_terminal_controller.sv
`timescale 1ns/100ps
`include "dtc_cfg.svh"
module display_terminal_controller
  import dtc_pkg::*;
#(
  parameter int unsigned BLINK_HALF = `BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // data-in port
  input wire logic [7:0] dinData,
  input wire logic dinValid,
  output logic dinReady,
  input wire logic endOfEntryKey,
  // data-out port
  output logic [7:0] doutWord,
  output logic doutStrobe,
  // code memory and column drive
  output logic [9:0] codeAddr,
  input wire logic [7:0] codeData,
  output logic [6:0] colData,
  output logic [2:0] colIdx,
  output logic [5:0] charIdx,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [6:0] textBuf_r [`MAX_CHARS];
  entry_mode_t mode_r;
  logic [3:0] lenCode_r;
  logic [5:0] cursor_r;
  ctl_state_t state_r, state_nxt;
  logic cfgDone_r, dinReady_r;
  logic [5:0] rbCount_r;
  logic rbPhase_r, doutStrobe_r;
  logic [7:0] doutWord_r;
  font_sel_t fontSel_r;
  logic [`EV_WIDTH-1:0] evStat_r, evMask_r;
  logic irq_r, pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic [5:0] scanChar_r, pipeChar_r;
  logic [2:0] scanCol_r, pipeCol_r;
  logic [9:0] codeAddr_r;
  logic [6:0] colData_r;
  logic [2:0] colIdx_r;
  logic [5:0] charIdx_r;
  logic blinkPhase;
  logic [9:0] fontAddr;

  // ----------------------------------------------------------------
  // decode of the data-in word
  // ----------------------------------------------------------------
  wire take = dinValid && dinReady_r;
  wire isCfg = take && (state_r == ST_IDLE) && (dinData[7:6] == `CFG_TAG);
  wire isCmd = take && (state_r == ST_IDLE) && (dinData[7:6] == `CMD_TAG);
  wire isChar = take && (state_r == ST_IDLE) && !dinData[7];
  wire isPos = take && (state_r == ST_ADDR);
  wire [2:0] cmd = dinData[2:0];
  wire [5:0] lenChars = {lenCode_r + 4'h1, 2'b00};
  wire [5:0] lastPos = lenChars - 6'h1;
  wire shortStr = (lenCode_r <= `LEN_CODE_32);

  // apb view
  wire apbSetup = psel && !penable;
  wire apbWr = psel && penable && pready_r && pwrite;
  wire cfgByApb = apbWr && (paddr == `REG_CONFIG);

  // configuration from data-in or apb, checked before it is applied
  wire [1:0] cfgMode = cfgByApb ? pwdata[5:4] : dinData[`CFG_MODE_HI:`CFG_MODE_LO];
  wire [3:0] cfgLen = cfgByApb ? pwdata[3:0] : dinData[`CFG_LEN_HI:`CFG_LEN_LO];
  wire cfgReq = isCfg || cfgByApb;
  wire cfgLegal = (cfgLen <= `LEN_CODE_MAX) &&
    !((cfgMode == 2'(ENTRY_DIRECT)) && (cfgLen > `LEN_CODE_32));
  wire cfgApply = cfgReq && cfgLegal;

  // the word on data-in at the first edge after release is a strap
  wire strapCfg = (dinData[7:6] == `CFG_TAG) &&
    (dinData[`CFG_LEN_HI:`CFG_LEN_LO] <= `LEN_CODE_MAX) &&
    !((dinData[5:4] == 2'(ENTRY_DIRECT)) && (dinData[3:0] > `LEN_CODE_32));

  wire readReq = isCmd && (cmd == `CMD_READ);
  wire readOk = readReq && shortStr;
  wire posOk = isPos && (dinData[5:0] <= lastPos);
  wire rbLast = (state_r == ST_READ) && rbPhase_r && (rbCount_r == `RB_WORDS - 6'h1);
  wire refused = (cfgReq && !cfgLegal) || (readReq && !shortStr) || (isPos && !posOk) ||
    (isCmd && (cmd == `CMD_SETPOS) && (mode_r != ENTRY_DIRECT));

  // ----------------------------------------------------------------
  // control sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (readOk) begin
          state_nxt = ST_READ;
        end else if (isCmd && (cmd == `CMD_SETPOS) && (mode_r == ENTRY_DIRECT)) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (take) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_READ: begin
        if (rbLast) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      dinReady_r <= 1'b0;
      cfgDone_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfgDone_r <= 1'b1;
      // one idle cycle after every word; none during read-back
      dinReady_r <= cfgDone_r && !take && (state_nxt != ST_READ);
    end
  end

  // ----------------------------------------------------------------
  // configuration, cursor and text
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= ENTRY_LEFT;
      lenCode_r <= `DEF_LEN_CODE;
      cursor_r <= 6'h0;
    end else if (!cfgDone_r) begin
      if (strapCfg) begin
        mode_r <= entry_mode_t'(dinData[5:4]);
        lenCode_r <= dinData[3:0];
      end
    end else if (cfgApply) begin
      mode_r <= entry_mode_t'(cfgMode);
      lenCode_r <= cfgLen;
      cursor_r <= 6'h0;
    end else if (isChar) begin
      if (mode_r == ENTRY_LEFT || mode_r == ENTRY_BLOCK || mode_r == ENTRY_DIRECT) begin
        // block entry wraps to the start; left entry stops at the end
        cursor_r <= (cursor_r == lastPos) ? ((mode_r == ENTRY_LEFT) ? cursor_r : 6'h0) :
          cursor_r + 6'h1;
      end
    end else if (posOk) begin
      cursor_r <= dinData[5:0];
    end else if (isCmd) begin
      if (cmd == `CMD_CLEAR) begin
        cursor_r <= 6'h0;
      end else if (cmd == `CMD_BACK && cursor_r != 6'h0) begin
        cursor_r <= cursor_r - 6'h1;
      end else if (cmd == `CMD_FWD && cursor_r != lastPos) begin
        cursor_r <= cursor_r + 6'h1;
      end
    end
  end

  // text buffer edits; positions beyond the string are kept blank
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `MAX_CHARS; i++) begin
        textBuf_r[i] <= `SPACE_CODE;
      end
    end else if (cfgApply || (isCmd && cmd == `CMD_CLEAR)) begin
      for (int i = 0; i < `MAX_CHARS; i++) begin
        textBuf_r[i] <= `SPACE_CODE;
      end
    end else if (isChar && mode_r == ENTRY_RIGHT) begin
      for (int i = 0; i < `MAX_CHARS - 1; i++) begin
        if (6'(i) < lastPos) begin
          textBuf_r[i] <= textBuf_r[i + 1];
        end
      end
      textBuf_r[lastPos] <= dinData[6:0];
    end else if (isChar) begin
      textBuf_r[cursor_r] <= dinData[6:0];
    end else if (isCmd && cmd == `CMD_INSERT) begin
      for (int i = 1; i < `MAX_CHARS; i++) begin
        if (6'(i) > cursor_r && 6'(i) <= lastPos) begin
          textBuf_r[i] <= textBuf_r[i - 1];
        end
      end
      textBuf_r[cursor_r] <= `SPACE_CODE;
    end else if (isCmd && cmd == `CMD_DELETE) begin
      for (int i = 0; i < `MAX_CHARS - 1; i++) begin
        if (6'(i) >= cursor_r && 6'(i) < lastPos) begin
          textBuf_r[i] <= textBuf_r[i + 1];
        end
      end
      textBuf_r[lastPos] <= `SPACE_CODE;
    end
  end

  // ----------------------------------------------------------------
  // read-back: status, cursor, then thirty-two characters
  // ----------------------------------------------------------------
  wire [7:0] rbWord = (rbCount_r == 6'h0) ? {2'b00, 2'(mode_r), lenCode_r} :
    (rbCount_r == 6'h1) ? {2'b00, cursor_r} :
    {1'b0, textBuf_r[rbCount_r - 6'h2]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rbCount_r <= 6'h0;
      rbPhase_r <= 1'b0;
      doutStrobe_r <= 1'b0;
      doutWord_r <= 8'h00;
    end else begin
      doutStrobe_r <= (state_r == ST_READ) && !rbPhase_r;
      if (state_r == ST_READ) begin
        rbPhase_r <= ~rbPhase_r;
        if (!rbPhase_r) begin
          doutWord_r <= rbWord;
        end else begin
          rbCount_r <= rbLast ? 6'h0 : rbCount_r + 6'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // column scan and font lookup
  // ----------------------------------------------------------------
  font_addr u_font (
    .charCode(textBuf_r[scanChar_r]),
    .col(scanCol_r),
    .fontSel(fontSel_r),
    .addr(fontAddr)
  );

  blink_timer #(.HALF_CYCLES(BLINK_HALF)) u_blink (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .phase(blinkPhase)
  );

  wire showCursor = (mode_r == ENTRY_LEFT) && blinkPhase && (pipeChar_r == cursor_r);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scanChar_r <= 6'h0;
      scanCol_r <= 3'h0;
      pipeChar_r <= 6'h0;
      pipeCol_r <= 3'h0;
      colData_r <= 7'h00;
      colIdx_r <= 3'h0;
      charIdx_r <= 6'h0;
    end else begin
      scanCol_r <= (scanCol_r == 3'h4) ? 3'h0 : scanCol_r + 3'h1;
      if (scanCol_r == 3'h4) begin
        scanChar_r <= (scanChar_r >= lastPos) ? 6'h0 : scanChar_r + 6'h1;
      end
      pipeChar_r <= scanChar_r;
      pipeCol_r <= scanCol_r;
      // code memory answers within the same cycle as its address
      colData_r <= showCursor ? `CURSOR_COL : codeData[6:0];
      colIdx_r <= pipeCol_r;
      charIdx_r <= pipeChar_r;
    end
  end

  // code memory address is registered by the lookup pipeline
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      codeAddr_r <= 10'h0;
    end else begin
      codeAddr_r <= fontAddr;
    end
  end

  // ----------------------------------------------------------------
  // apb registers and interrupt
  // ----------------------------------------------------------------
  wire [`EV_WIDTH-1:0] evSet = {refused, endOfEntryKey, rbLast};
  wire mapped = (paddr == `REG_CONFIG) || (paddr == `REG_FONT) || (paddr == `REG_STATUS) ||
    (paddr == `REG_MASK) || (paddr == `REG_CURSOR);
  wire [31:0] rdSel = (paddr == `REG_CONFIG) ? {26'h0, 2'(mode_r), lenCode_r} :
    (paddr == `REG_FONT) ? {30'h0, 2'(fontSel_r)} :
    (paddr == `REG_STATUS) ? {29'h0, evStat_r} :
    (paddr == `REG_MASK) ? {29'h0, evMask_r} :
    (paddr == `REG_CURSOR) ? {24'h0, (state_r == ST_READ), 1'b0, cursor_r} : 32'h0;
  wire [`EV_WIDTH-1:0] w1c = (apbWr && paddr == `REG_STATUS) ? pwdata[`EV_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
      evStat_r <= '0;
      evMask_r <= '0;
      fontSel_r <= FONT_128;
      irq_r <= 1'b0;
    end else begin
      pready_r <= apbSetup;
      pslverr_r <= apbSetup && !mapped;
      prdata_r <= apbSetup ? rdSel : 32'h0;
      // a new event wins over a clear in the same cycle
      evStat_r <= (evStat_r & ~w1c) | evSet;
      if (apbWr && paddr == `REG_MASK) begin
        evMask_r <= pwdata[`EV_WIDTH-1:0];
      end
      if (apbWr && paddr == `REG_FONT && pwdata[1:0] <= 2'(FONT_EXT)) begin
        fontSel_r <= font_sel_t'(pwdata[1:0]);
      end
      irq_r <= |(((evStat_r & ~w1c) | evSet) & evMask_r);
    end
  end

  assign codeAddr = codeAddr_r;
  assign dinReady = dinReady_r;
  assign doutWord = doutWord_r;
  assign doutStrobe = doutStrobe_r;
  assign colData = colData_r;
  assign colIdx = colIdx_r;
  assign charIdx = charIdx_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence rbStart;
    readOk ##1 (state_r == ST_READ);
  endsequence
  sequence rbFirstWord;
    doutStrobe_r[*1] ##1 !doutStrobe_r;
  endsequence

  chk_len_step: assert property (lenCode_r <= `LEN_CODE_MAX)
    else $error("string length code out of range");
  chk_direct_len: assert property (mode_r == ENTRY_DIRECT |-> lenCode_r <= `LEN_CODE_32)
    else $error("direct entry with string over 32");
  chk_cursor_mode: assert property (
    ($past(mode_r) != ENTRY_LEFT) && $past(rst_n) |-> colData_r == $past(codeData[6:0]))
    else $error("cursor shown outside left entry");
  chk_rb_short: assert property (doutStrobe_r |-> lenCode_r <= `LEN_CODE_32)
    else $error("read-back with long string");
  chk_rb_words: assert property (rbStart |=> rbFirstWord ##[60:70] (state_r == ST_IDLE))
    else $error("read-back length wrong");
  chk_ready_gap: assert property (take |=> !dinReady_r)
    else $error("ready did not drop after a word");
  chk_clear_edit: assert property (
    (isCmd && cmd == `CMD_CLEAR && !cfgApply) |=> cursor_r == 6'h0 && textBuf_r[0] == `SPACE_CODE)
    else $error("clear did not blank the text");
  chk_cfg_apply: assert property (
    (cfgApply && cfgDone_r) |=> (2'(mode_r) == $past(cfgMode)) && (lenCode_r == $past(cfgLen)))
    else $error("configuration word not applied");
  chk_strap: assert property (
    $rose(cfgDone_r) && !$past(strapCfg) |-> mode_r == ENTRY_LEFT && lenCode_r == `DEF_LEN_CODE)
    else $error("default configuration wrong");
  chk_font_col: assert property (
    !$past(showCursor) && $past(rst_n) |-> colData_r == $past(codeData[6:0]))
    else $error("column data does not follow code memory");
endmodule // display_terminal_controller

// File: bench/host_feeder.sv
`timescale 1ns/100ps
module host_feeder (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bench side
  input wire logic [7:0] strapWord,
  input wire logic sendReq,
  input wire logic [7:0] sendWord,
  output logic sendBusy,
  // device data-in port
  output logic [7:0] dinData,
  output logic dinValid,
  input wire logic dinReady
);
  // ----------------------------------------------------------------
  // latched word toward the device
  // ----------------------------------------------------------------
  // host and keyboard share one port; this model is its only source
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dinData <= strapWord;
      dinValid <= 1'b0;
      sendBusy <= 1'b0;
    end else if (dinValid && dinReady) begin
      // released lines change so a stale word cannot pass as fresh
      dinData <= ~dinData;
      dinValid <= 1'b0;
      sendBusy <= 1'b0;
    end else if (sendReq && !sendBusy) begin
      dinData <= sendWord;
      dinValid <= 1'b1;
      sendBusy <= 1'b1;
    end
  end
endmodule // host_feeder

// File: bench/display_terminal_controller_tb.sv
`timescale 1ns/100ps
module display_terminal_controller_tb;
  logic clk_sys, rst_n, sendReq, sendBusy, dinValid, dinReady, endOfEntryKey, doutStrobe;
  logic [7:0] strapWord, sendWord, dinData, doutWord, codeData, paddr;
  logic [9:0] codeAddr;
  logic [6:0] colData;
  logic [2:0] colIdx;
  logic [5:0] charIdx;
  logic psel, penable, pwrite, pready, pslverr, irq, er;
  logic [31:0] pwdata, prdata, rd;
  int n_errors, n_checks, cur, md, ln, st, nc, nb, k, m, t;
  int txt[48];
  bit pend, f64;

  // code memory answer never equals the cursor block pattern
  assign codeData = {2'b00, codeAddr[5:0]};

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  host_feeder host (.clk_sys(clk_sys), .rst_n(rst_n), .strapWord(strapWord),
    .sendReq(sendReq), .sendWord(sendWord), .sendBusy(sendBusy), .dinData(dinData),
    .dinValid(dinValid), .dinReady(dinReady));

  display_terminal_controller #(.BLINK_HALF(13)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .dinData(dinData), .dinValid(dinValid), .dinReady(dinReady),
    .endOfEntryKey(endOfEntryKey), .doutWord(doutWord), .doutStrobe(doutStrobe),
    .codeAddr(codeAddr), .codeData(codeData), .colData(colData), .colIdx(colIdx),
    .charIdx(charIdx), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  // ----------------------------------------------------------------
  // reference model of text, cursor and status
  // ----------------------------------------------------------------
  task clr;
    for (int i = 0; i < 48; i++) txt[i] = 32;
    cur = 0;
  endtask

  task cfg(input int w);
    md = (w >> 4) & 3;
    ln = ((w & 15) + 1) * 4;
    clr();
  endtask

  function automatic bit bad(input int w);
    return (w & 15) > 11 || (((w >> 4) & 3) == 2 && (w & 15) > 7);
  endfunction

  function automatic int cfgw();
    return md * 16 + ln / 4 - 1;
  endfunction

  task mdl(input int w);
    if (pend) begin
      pend = 0;
      if (w < ln) cur = w;
      else st |= 4;
    end else if (w >= 8'hc0) begin
      if (bad(w)) st |= 4;
      else cfg(w);
    end else if (w < 8'h80) begin
      case (md)
        0: begin
          txt[cur] = w;
          if (cur < ln - 1) cur++;
        end
        1: begin
          for (int i = 0; i < ln - 1; i++) txt[i] = txt[i + 1];
          txt[ln - 1] = w;
        end
        default: begin
          txt[cur] = w;
          cur = (cur + 1) % ln;
        end
      endcase
    end else begin
      case (w & 7)
        0: clr();
        1: if (cur > 0) cur--;
        2: if (cur < ln - 1) cur++;
        3: begin
          for (int i = ln - 1; i > cur; i--) txt[i] = txt[i - 1];
          txt[cur] = 32;
        end
        4: begin
          for (int i = cur; i < ln - 1; i++) txt[i] = txt[i + 1];
          txt[ln - 1] = 32;
        end
        5: if (ln > 32) st |= 4;
        default: if (md == 2) pend = 1; else st |= 4;
      endcase
    end
  endtask

  // ----------------------------------------------------------------
  // drivers and comparisons
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task send(input logic [7:0] w);
    mdl(w);
    sendWord <= w;
    sendReq <= 1'b1;
    @(posedge clk_sys);
    sendReq <= 1'b0;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (sendBusy !== 1'b0 && t < 50);
    if (t >= 50) chk("handshake", 0, t);
  endtask

  task rb;
    int e;
    send(8'h85);
    if (ln > 32) begin
      nc = 0;
      repeat (20) begin
        @(posedge clk_sys);
        if (doutStrobe === 1'b1) nc++;
      end
      chk("refused strobes", 0, nc);
    end else begin
      for (k = 0; k < 34; k++) begin
        t = 0;
        do begin
          @(posedge clk_sys);
          t++;
        end while (doutStrobe !== 1'b1 && t < 10);
        chk("word spacing", (k == 0) ? 1 : 2, t);
        e = (k == 0) ? cfgw() : (k == 1) ? cur : txt[k - 2];
        if (k < ln + 2) chk("read word", e, doutWord);
      end
      st |= 1;
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rdchk(input logic [7:0] a, input int e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task waitIrq(input logic v);
    t = 0;
    while (irq !== v && t < 10) begin
      @(posedge clk_sys);
      t++;
    end
    chk("irq", v, irq);
  endtask

  task watch;
    nc = 0;
    nb = 0;
    for (int i = 0; i < 1500; i++) begin
      @(posedge clk_sys);
      if (colData === 7'h7f) begin
        nc++;
        chk("cursor char", cur, charIdx);
      end else if (i > 3 && !f64) begin
        chk("column data", {1'b0, 6'(txt[charIdx])}, colData);
      end
      chk("column index", 1, colIdx <= 3'h4);
      if (codeAddr[6] === 1'b1) nb++;
    end
  endtask

  task doReset(input logic [7:0] s);
    rst_n <= 1'b0;
    strapWord <= s;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    if (s >= 8'hc0 && !bad(s)) cfg(s);
    else cfg(8'hc7);
    st = 0;
    pend = 0;
  endtask

  task conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    conclude();
  end

  initial begin
    {rst_n, psel, penable, pwrite, sendReq, endOfEntryKey} = '0;
    {paddr, pwdata, sendWord, strapWord} = '0;
    n_errors = 0;
    n_checks = 0;
    f64 = 0;
    void'($urandom(21227));
    doReset(8'h00);
    rdchk(8'h00, cfgw(), "config");
    rdchk(8'h04, 1, "font");
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", 1, er);
    rb();
    watch();
    chk("cursor left", 1, nc > 0);
    for (m = 0; m < 4; m++) begin
      send(8'(8'hc3 | (m << 4)));
      repeat (18) begin
        if (m == 2) begin
          send(8'h86);
          send(8'($urandom % ln));
        end
        send(8'(8'h21 + $urandom % 94));
      end
      rb();
      watch();
      chk("cursor mode", m == 0, nc > 0);
    end
    send(8'hc7);
    repeat (6) send(8'(8'h21 + $urandom % 94));
    send(8'h81);
    send(8'h81);
    send(8'h83);
    send(8'h84);
    send(8'h82);
    send(8'h84);
    rb();
    send(8'h80);
    rb();
    for (m = 0; m < 16; m++) begin
      send(8'(8'hc0 | m));
      rdchk(8'h00, cfgw(), "length code");
    end
    send(8'he8);
    send(8'hc8);
    rb();
    send(8'h86);
    rdchk(8'h08, st, "status refused");
    apb(1'b1, 8'h08, 32'h7);
    st = 0;
    apb(1'b1, 8'h0c, 32'h1);
    send(8'hc7);
    rb();
    waitIrq(1'b1);
    apb(1'b1, 8'h08, 32'h1);
    st = 0;
    waitIrq(1'b0);
    apb(1'b1, 8'h0c, 32'h2);
    endOfEntryKey <= 1'b1;
    @(posedge clk_sys);
    endOfEntryKey <= 1'b0;
    st |= 2;
    waitIrq(1'b1);
    rdchk(8'h08, st, "status key");
    apb(1'b1, 8'h08, 32'h7);
    waitIrq(1'b0);
    send(8'h41);
    send(8'h5a);
    apb(1'b1, 8'h04, 32'h0);
    f64 = 1;
    watch();
    chk("font64 index", 0, nb);
    apb(1'b1, 8'h04, 32'h1);
    f64 = 0;
    watch();
    chk("font128 index", 1, nb > 0);
    rdchk(8'h10, cur, "cursor reg");
    mdl(8'hf2);
    apb(1'b1, 8'h00, 32'h32);
    rdchk(8'h00, cfgw(), "apb config");
    apb(1'b1, 8'h04, 32'h2);
    rdchk(8'h04, 2, "font ext");
    doReset(8'hd3);
    rdchk(8'h00, cfgw(), "strap config");
    rb();
    conclude();
  end
endmodule // display_terminal_controller_tb
